/* File: logic/cg_cfg.svh */
/*
  Offsets, field positions, synchroniser lanes and counts of the clock block.
  Assumes inclusion by bare name from the clock generator files.
*/
`ifndef CG_CFG_SVH
`define CG_CFG_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CG_ADDR_CLOCK 8'h00
`define CG_ADDR_MISC 8'h04
`define CG_ADDR_PRE 8'h08
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CG_CK_CPUSEL 0
`define CG_CK_RCEN 1
`define CG_CK_XEN 2
`define CG_CK_COLD 3
`define CG_CK_EXTEN 4
`define CG_CK_EXTAV 5
`define CG_MI_WAKE 0
`define CG_MI_DEBF 1
`define CG_MI_XOUT 2
`define CG_MI_COUT 3
`define CG_PR_RST 0
`define CG_PR_LOW_LSB 8
// ----------------------------------------
// Synchroniser lanes
// ----------------------------------------
`define CG_IN_RC 0
`define CG_IN_XT 1
`define CG_IN_EXT 2
`define CG_IN_PA 3
// ----------------------------------------
// Counts and rates
// ----------------------------------------
`define CG_EXT_PULSES 4
`define CG_XTAL_STARTUP 37268
`define CG_RC_HZ 1000000
`define CG_TAP_HZ 32768
`define CG_DEB_FAST_TAP 1
`define CG_DEB_SLOW_TAP 6
`endif

/* File: logic/cg_pkg.sv */
/*
  Types of the clock generator: switch states, sources, state records.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cg_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_PARK = 3'h2,
    ST_JOIN = 3'h4
  } sw_state_t;
  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_RC = 2'h1,
    SRC_XTAL = 2'h2,
    SRC_EXT = 2'h3
  } src_t;
  typedef struct packed {
    logic cpu_sel;
    logic rc_en;
    logic xtal_en;
    logic xtal_cold;
    logic ext_en;
    logic ext_avail;
    logic wake;
    logic deb_fast;
    logic xtal_out;
    logic cpu_out;
    logic sleep_seen;
    logic [2:0] ext_cnt;
    logic [15:0] xtal_cnt;
    sw_state_t state;
    src_t cur;
    logic cpu_clk;
    logic pb2;
    logic pb3;
    logic deb_clk;
    logic [31:0] rdata;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] filt;
  } ctrl_t;
  typedef struct packed {
    logic [14:0] low;
    logic [7:0] high;
  } pre_t;
endpackage

/* File: logic/cg_clock_gen.sv */
/*
  Processor clock source selection, glitch-free switching, external clock
  detection, crystal start-up flag and the two prescaler chains, with an
  APB register slave.
  Assumes oscillator clocks and pins arrive unsynchronised and far slower
  than pclk; sleep_reset comes from the system sleep logic.
*/
// The address map and the APB interface to the registers are this design's own decisions.
// Functional notes
// RQ1: Four oscin pulses detect the external clock
// RQ2: Readable external clock available flag
// RQ3: External clock feeds processor clock only
// RQ4: Power-up and sleep exit select RC
// RQ5: Select bit picks RC, crystal or external
// RQ6: Source changes never shorten a clock phase
// RQ7: Disabled RC stops clocks as tabled
// RQ8: Software switches sources in three writes
// RQ9: Wake option sets RC enable on pin
// RQ10: Debounce clock 256 Hz or 8 kHz
// RQ11: Crystal clock to port B bit 3
// RQ12: Processor clock to port B bit 2
// RQ13: Eight and fifteen stage divider chains
// RQ14: High prescaler runs from enabled RC only
// RQ15: Low prescaler from crystal or high prescaler
// RQ16: Low prescaler cleared by write or crystal enable
// RQ17: Sleep reset clears both chains asynchronously
// RQ18: Start-up flag held for start-up count
// RQ19: Tap nearest 32 kHz feeds low prescaler
// RQ20: Crystal unusable while external clock used
// RQ21: Crystal enable blocked under external clock
// RQ22: Reset and sleep clear crystal, set flag
// RQ23: Sleep clears RC enable
// RQ24: External enable clear restarts detection
`include "cg_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module cg_clock_gen #(
  parameter int XTAL_STARTUP = `CG_XTAL_STARTUP,
  parameter int RC_HZ = `CG_RC_HZ
) (
  // Clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sleep_reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillators and pins
  input wire logic rc_clock_in,
  input wire logic crystal_clock_in,
  input wire logic oscin_pin,
  input wire logic port_a_bit0,
  // Clock outputs
  output logic rc_oscillator_run,
  output logic crystal_oscillator_run,
  output logic cpu_clock,
  output logic port_b_bit2,
  output logic port_b_bit3,
  output logic debounce_clock,
  output logic [7:0] high_prescaler,
  output logic [14:0] low_prescaler
);
  // ----------------------------------------
  // Tap decoder
  // ----------------------------------------
  function automatic int tap_for(int hz);
    int best;
    int err;
    int e;
    best = 0;
    err = 32'h7fffffff;
    for (int k = 0; k < 8; k++) begin
      e = (hz >> (k + 1)) - `CG_TAP_HZ;
      if (e < 0) begin
        e = -e;
      end
      if (e < err) begin
        err = e;
        best = k;
      end
    end
    return best;
  endfunction

  localparam int TAP = tap_for(RC_HZ); // RQ19

  function automatic logic src_level(cg_pkg::src_t s, logic [3:0] f);
    case (s)
      cg_pkg::SRC_RC: src_level = f[`CG_IN_RC];
      cg_pkg::SRC_XTAL: src_level = f[`CG_IN_XT];
      cg_pkg::SRC_EXT: src_level = f[`CG_IN_EXT];
      default: src_level = 1'b0;
    endcase
  endfunction

  cg_pkg::ctrl_t st;
  cg_pkg::ctrl_t next_st;
  cg_pkg::pre_t pr;
  cg_pkg::pre_t next_pr;
  logic xtal_ok;
  cg_pkg::src_t want;
  logic wr_ck;
  logic wr_mi;
  logic wr_pr;
  logic hit;

  // ----------------------------------------
  // Source decode
  // ----------------------------------------
  assign xtal_ok = st.xtal_en & ~st.ext_en & ~st.ext_avail; // RQ20
  assign want = !st.cpu_sel ? (st.rc_en ? cg_pkg::SRC_RC
                                        : cg_pkg::SRC_NONE) // RQ7
              : xtal_ok ? cg_pkg::SRC_XTAL // RQ5
              : st.ext_avail ? cg_pkg::SRC_EXT // RQ3
              : cg_pkg::SRC_NONE;
  assign hit = paddr == `CG_ADDR_CLOCK || paddr == `CG_ADDR_MISC
            || paddr == `CG_ADDR_PRE;
  assign wr_ck = psel & penable & pwrite & (paddr == `CG_ADDR_CLOCK);
  assign wr_mi = psel & penable & pwrite & (paddr == `CG_ADDR_MISC);
  assign wr_pr = psel & penable & pwrite & (paddr == `CG_ADDR_PRE);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [3:0] rise;
    logic hi_edge;
    logic lo_edge;
    rise = 4'h0;
    hi_edge = 1'b0;
    lo_edge = 1'b0;
    next_st = st;
    next_pr = pr;
    // Three-stage sync; level moves when stages two and three agree
    next_st.s1 = {port_a_bit0, oscin_pin, crystal_clock_in, rc_clock_in};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.filt = (st.s2 & ~(st.s2 ^ st.s3)) | (st.filt & (st.s2 ^ st.s3));
    rise = next_st.filt & ~st.filt;
    // Crystal start-up count
    if (st.xtal_en && st.xtal_cold && rise[`CG_IN_XT]) begin
      if (st.xtal_cnt == 16'(XTAL_STARTUP - 1)) begin
        next_st.xtal_cold = 1'b0; // RQ18
      end else begin
        next_st.xtal_cnt = st.xtal_cnt + 16'h1;
      end
    end
    // External clock detection
    if (!st.ext_en) begin
      next_st.ext_cnt = 3'h0; // RQ24
      next_st.ext_avail = 1'b0;
    end else if (rise[`CG_IN_EXT] && !st.ext_avail) begin
      if (st.ext_cnt == 3'(`CG_EXT_PULSES - 1)) begin
        next_st.ext_avail = 1'b1; // RQ1
      end else begin
        next_st.ext_cnt = st.ext_cnt + 3'h1;
      end
    end
    // Register writes
    if (wr_ck) begin
      next_st.cpu_sel = pwdata[`CG_CK_CPUSEL];
      next_st.rc_en = pwdata[`CG_CK_RCEN];
      next_st.ext_en = pwdata[`CG_CK_EXTEN];
      if (!pwdata[`CG_CK_XEN]) begin
        next_st.xtal_en = 1'b0;
        next_st.xtal_cold = 1'b1;
      end else if (!st.xtal_en && !st.ext_en && !st.ext_avail
                   && !pwdata[`CG_CK_EXTEN]) begin // RQ21
        next_st.xtal_en = 1'b1;
        next_st.xtal_cold = 1'b1;
        next_st.xtal_cnt = 16'h0;
      end
    end
    if (wr_mi) begin
      next_st.wake = pwdata[`CG_MI_WAKE];
      next_st.deb_fast = pwdata[`CG_MI_DEBF];
      next_st.xtal_out = pwdata[`CG_MI_XOUT];
      next_st.cpu_out = pwdata[`CG_MI_COUT];
    end
    // Wake on pin wins over a software clear
    if (st.wake && st.filt[`CG_IN_PA]) begin
      next_st.rc_en = 1'b1; // RQ9
    end
    // Sleep exit
    next_st.sleep_seen = sleep_reset;
    if (st.sleep_seen && !sleep_reset) begin
      next_st.rc_en = 1'b1; // RQ4
    end
    // Sleep entry
    if (sleep_reset) begin
      next_st.rc_en = 1'b0; // RQ23
      next_st.xtal_en = 1'b0; // RQ22
      next_st.xtal_cold = 1'b1;
      next_st.cpu_sel = 1'b0; // RQ4
    end
    // Prescaler chains
    hi_edge = st.rc_en & rise[`CG_IN_RC]; // RQ14
    if (hi_edge) begin
      next_pr.high = pr.high + 8'h1; // RQ13
    end
    lo_edge = xtal_ok ? rise[`CG_IN_XT] // RQ15
            : hi_edge & next_pr.high[TAP] & ~pr.high[TAP]; // RQ19
    if (lo_edge) begin
      next_pr.low = pr.low + 15'h1; // RQ13
    end
    if ((wr_pr && pwdata[`CG_PR_RST])
        || (next_st.xtal_en && !st.xtal_en)) begin
      next_pr.low = 15'h0; // RQ16
    end
    // Glitch-free processor clock switch
    unique case (st.state)
      cg_pkg::ST_RUN: begin
        next_st.cpu_clk = src_level(st.cur, st.filt);
        if (want != st.cur) begin
          next_st.state = cg_pkg::ST_PARK; // RQ6
        end
      end
      cg_pkg::ST_PARK: begin
        next_st.cpu_clk = st.cpu_clk & src_level(st.cur, st.filt);
        if (!next_st.cpu_clk) begin
          next_st.state = cg_pkg::ST_JOIN; // RQ6
        end
      end
      cg_pkg::ST_JOIN: begin
        next_st.cpu_clk = 1'b0;
        if (!src_level(want, st.filt)) begin
          next_st.cur = want; // RQ5
          next_st.state = cg_pkg::ST_RUN;
        end
      end
    endcase
    // Pin and debounce clocks
    next_st.pb2 = st.cpu_out & next_st.cpu_clk; // RQ12
    next_st.pb3 = st.xtal_out & st.xtal_en & st.filt[`CG_IN_XT]; // RQ11
    next_st.deb_clk = st.deb_fast ? pr.low[`CG_DEB_FAST_TAP]
                    : pr.low[`CG_DEB_SLOW_TAP]; // RQ10
    // Read data captured in the setup phase
    if (psel && !penable) begin
      next_st.rdata = 32'h0;
      case (paddr)
        `CG_ADDR_CLOCK: begin
          next_st.rdata[`CG_CK_CPUSEL] = st.cpu_sel;
          next_st.rdata[`CG_CK_RCEN] = st.rc_en;
          next_st.rdata[`CG_CK_XEN] = st.xtal_en;
          next_st.rdata[`CG_CK_COLD] = st.xtal_cold;
          next_st.rdata[`CG_CK_EXTEN] = st.ext_en;
          next_st.rdata[`CG_CK_EXTAV] = st.ext_avail; // RQ2
        end
        `CG_ADDR_MISC: begin
          next_st.rdata[`CG_MI_WAKE] = st.wake;
          next_st.rdata[`CG_MI_DEBF] = st.deb_fast;
          next_st.rdata[`CG_MI_XOUT] = st.xtal_out;
          next_st.rdata[`CG_MI_COUT] = st.cpu_out;
        end
        `CG_ADDR_PRE: begin
          next_st.rdata[7:0] = pr.high;
          next_st.rdata[`CG_PR_LOW_LSB +: 15] = pr.low;
        end
        default: next_st.rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.rc_en <= 1'b1; // RQ4
      st.xtal_cold <= 1'b1; // RQ22
      st.state <= cg_pkg::ST_RUN;
      st.cur <= cg_pkg::SRC_RC;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge pclk or negedge presetn or posedge sleep_reset) begin
    if (!presetn || sleep_reset) begin
      pr <= '0; // RQ17
    end else begin
      pr <= next_pr;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = st.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign rc_oscillator_run = st.rc_en;
  assign crystal_oscillator_run = st.xtal_en;
  assign cpu_clock = st.cpu_clk;
  assign port_b_bit2 = st.pb2;
  assign port_b_bit3 = st.pb3;
  assign debounce_clock = st.deb_clk;
  assign high_prescaler = pr.high;
  assign low_prescaler = pr.low;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  ext_detect_a: assert property ( // RQ1
    @(posedge pclk) disable iff (!presetn)
    $rose(st.ext_avail) |-> $past(st.ext_en) && $past(st.ext_cnt) == 3'h3)
    else $error("external clock flagged without four pulses");
  ext_restart_a: assert property ( // RQ24
    @(posedge pclk) disable iff (!presetn)
    !st.ext_en |=> !st.ext_avail && st.ext_cnt == 3'h0)
    else $error("detection not restarted");
  high_stop_a: assert property ( // RQ14
    @(posedge pclk) disable iff (!presetn || sleep_reset)
    !st.rc_en |=> $stable(pr.high))
    else $error("high prescaler moved without RC");
  ext_only_a: assert property ( // RQ7
    @(posedge pclk) disable iff (!presetn || sleep_reset)
    st.ext_en && !st.rc_en && !wr_pr |=> $stable(pr.low))
    else $error("low prescaler moved on external clock");
  switch_start_a: assert property ( // RQ5
    @(posedge pclk) disable iff (!presetn)
    st.state == cg_pkg::ST_RUN && want != st.cur
      |=> st.state == cg_pkg::ST_PARK)
    else $error("source change not started");
  glitch_free_a: assert property ( // RQ6
    @(posedge pclk) disable iff (!presetn)
    $rose(st.cpu_clk) |-> $past(st.state) == cg_pkg::ST_RUN)
    else $error("processor clock rose while switching");
  sleep_clear_a: assert property ( // RQ23
    @(posedge pclk) disable iff (!presetn)
    sleep_reset |=> !st.rc_en && !st.xtal_en && st.xtal_cold)
    else $error("sleep left an oscillator on");
  sleep_exit_a: assert property ( // RQ4
    @(posedge pclk) disable iff (!presetn)
    st.sleep_seen && !sleep_reset |=> st.rc_en)
    else $error("sleep exit did not enable RC");
  xtal_block_a: assert property ( // RQ21
    @(posedge pclk) disable iff (!presetn)
    (st.ext_en || st.ext_avail) && !st.xtal_en |=> !st.xtal_en)
    else $error("crystal enabled under external clock");
  wake_pin_a: assert property ( // RQ9
    @(posedge pclk) disable iff (!presetn)
    st.wake && st.filt[`CG_IN_PA] && !sleep_reset |=> st.rc_en)
    else $error("wake pin did not enable RC");
  pin_low_a: assert property ( // RQ11
    @(posedge pclk) disable iff (!presetn)
    !st.xtal_en |=> !st.pb3)
    else $error("crystal pin active while crystal off");
  xtal_start_a: assert property ( // RQ16
    @(posedge pclk) disable iff (!presetn || sleep_reset)
    $rose(st.xtal_en) |-> st.xtal_cold && pr.low == 15'h0)
    else $error("crystal start did not clear low chain");
endmodule
`default_nettype wire

/* File: tb/osc_model.sv */
/*
  Oscillator model: RC and crystal clocks while enabled, external clock
  pulses on demand. Assumes the bench calls pulses between checks.
*/
`timescale 1ns/1ns
`default_nettype none
module osc_model (
  // Enables
  input wire logic rc_run,
  input wire logic xt_run,
  // Clocks
  output logic rc_clk,
  output logic xt_clk,
  output logic ext_clk
);
  // ----------------------------------------
  // Clocks
  // ----------------------------------------
  initial begin
    rc_clk = 0;
    xt_clk = 0;
    ext_clk = 0;
  end
  always #40 rc_clk = rc_run ? ~rc_clk : 1'b0;
  always #56 xt_clk = xt_run ? ~xt_clk : 1'b0;
  // External clock idles low between bursts
  task automatic pulses(input int n);
    repeat (n) begin
      ext_clk = 1;
      #48;
      ext_clk = 0;
      #48;
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
/*
  Directed bench for the clock generator over APB.
  Assumes cg_clock_gen and osc_model are compiled before it.
*/
`include "cg_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic pclk = 0;
  logic presetn = 0;
  logic sleep_reset = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic pready, pslverr, rc_ck, xt_ck, ext_ck, rc_run, xt_run;
  logic pa0 = 0;
  logic cpu_clock, pb2, pb3, deb, e;
  logic [7:0] hp;
  logic [14:0] lp;
  logic [31:0] d;
  logic [22:0] q;
  int n_fail = 0;
  int checked = 0;
  int c;
  always #4 pclk = ~pclk;
  cg_clock_gen #(.XTAL_STARTUP(8)) dut (.pclk(pclk), .presetn(presetn),
    .sleep_reset(sleep_reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rc_clock_in(rc_ck),
    .crystal_clock_in(xt_ck), .oscin_pin(ext_ck), .port_a_bit0(pa0),
    .rc_oscillator_run(rc_run), .crystal_oscillator_run(xt_run),
    .cpu_clock(cpu_clock), .port_b_bit2(pb2), .port_b_bit3(pb3),
    .debounce_clock(deb), .high_prescaler(hp), .low_prescaler(lp));
  osc_model osc (.rc_run(rc_run), .xt_run(xt_run), .rc_clk(rc_ck),
    .xt_clk(xt_ck), .ext_clk(ext_ck));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string s, input logic [31:0] x,
                     input logic [31:0] g);
    checked++;
    if (g !== x) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] v);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    acc(1, a, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string s);
    acc(0, a, 0);
    chk(s, x, d);
  endtask
  task automatic edges(input int id, input int n, output int k);
    logic [4:0] v, p;
    k = 0;
    p = {deb, hp[0], pb3, pb2, cpu_clock};
    repeat (n) begin
      @(posedge pclk);
      v = {deb, hp[0], pb3, pb2, cpu_clock};
      if (v[id] !== p[id]) k++;
      p = v;
    end
  endtask
  task automatic summarize;
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(`CG_ADDR_CLOCK, 32'h0000000a, "clock reset");
    rd(`CG_ADDR_MISC, 32'h00000000, "misc reset");
    rd(8'h0c, 32'h00000000, "unmapped data");
    chk("unmapped error", 1, e);
    wr(`CG_ADDR_CLOCK, 32'h00000016);
    rd(`CG_ADDR_CLOCK, 32'h0000001a, "crystal refused");
    osc.pulses(3);
    repeat (8) @(posedge pclk);
    rd(`CG_ADDR_CLOCK, 32'h0000001a, "three pulses");
    osc.pulses(1);
    repeat (8) @(posedge pclk);
    rd(`CG_ADDR_CLOCK, 32'h0000003a, "four pulses");
    wr(`CG_ADDR_CLOCK, 32'h00000013);
    wr(`CG_ADDR_CLOCK, 32'h00000011);
    q = {lp, hp};
    fork
      osc.pulses(4);
      edges(0, 60, c);
    join
    chk("cpu ext", 1, c > 0);
    chk("ext only", q, {lp, hp});
    wr(`CG_ADDR_CLOCK, 32'h00000013);
    wr(`CG_ADDR_CLOCK, 32'h00000012);
    wr(`CG_ADDR_CLOCK, 32'h00000002);
    rd(`CG_ADDR_CLOCK, 32'h0000000a, "ext cleared");
    wr(`CG_ADDR_CLOCK, 32'h00000012);
    osc.pulses(3);
    repeat (8) @(posedge pclk);
    rd(`CG_ADDR_CLOCK, 32'h0000001a, "count restart");
    wr(`CG_ADDR_CLOCK, 32'h00000002);
    repeat (400) @(posedge pclk);
    chk("low from tap", 1, lp != 15'h0);
    wr(`CG_ADDR_CLOCK, 32'h00000006);
    acc(0, `CG_ADDR_PRE, 0);
    chk("low cleared", 0, d[22:8]);
    chk("high runs", 1, d[7:0] != 8'h0);
    repeat (70) @(posedge pclk);
    rd(`CG_ADDR_CLOCK, 32'h0000000e, "startup held");
    repeat (120) @(posedge pclk);
    rd(`CG_ADDR_CLOCK, 32'h00000006, "startup over");
    wr(`CG_ADDR_MISC, 32'h0000000e);
    edges(2, 100, c); chk("pb3 runs", 1, c > 0);
    edges(1, 100, c); chk("pb2 runs", 1, c > 0);
    edges(4, 400, c); chk("fast deb", 1, c > 4);
    wr(`CG_ADDR_MISC, 32'h0000000c);
    repeat (2) @(posedge pclk);
    edges(4, 400, c); chk("slow deb", 1, c <= 1);
    wr(`CG_ADDR_PRE, 32'h00000001);
    acc(0, `CG_ADDR_PRE, 0); chk("pre reset", 0, d[22:10]);
    wr(`CG_ADDR_CLOCK, 32'h00000007);
    wr(`CG_ADDR_CLOCK, 32'h00000005);
    repeat (10) @(posedge pclk);
    edges(0, 100, c); chk("cpu xtal", 1, c > 0);
    edges(3, 100, c); chk("high stop", 0, c);
    wr(`CG_ADDR_CLOCK, 32'h00000007);
    wr(`CG_ADDR_CLOCK, 32'h00000006);
    wr(`CG_ADDR_CLOCK, 32'h00000002);
    repeat (10) @(posedge pclk);
    edges(2, 100, c); chk("pb3 held", 0, c);
    chk("pb3 low", 0, pb3);
    edges(0, 100, c); chk("cpu rc", 1, c > 0);
    wr(`CG_ADDR_CLOCK, 32'h00000000);
    repeat (10) @(posedge pclk);
    edges(0, 100, c); chk("cpu off", 0, c);
    wr(`CG_ADDR_CLOCK, 32'h00000006);
    repeat (40) @(posedge pclk);
    sleep_reset <= 1;
    @(posedge pclk);
    #1 chk("sleep high", 0, hp);
    chk("sleep low", 0, lp);
    chk("sleep rc", 0, rc_run);
    chk("sleep xtal", 0, xt_run);
    @(posedge pclk);
    sleep_reset <= 0;
    @(posedge pclk);
    rd(`CG_ADDR_CLOCK, 32'h0000000a, "after sleep");
    wr(`CG_ADDR_MISC, 32'h00000001);
    wr(`CG_ADDR_CLOCK, 32'h00000000);
    rd(`CG_ADDR_CLOCK, 32'h00000008, "rc off");
    pa0 <= 1;
    repeat (10) @(posedge pclk);
    rd(`CG_ADDR_CLOCK, 32'h0000000a, "wake on pin");
    summarize();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    summarize();
  end
endmodule
`default_nettype wire
